// File: bench/sfpg_host_model.sv
`timescale 1ns/1ps
module sfpg_host_model import sfpg_pkg::*; (
  input  wire logic       clk,
  input  wire logic       select_allowed,
  input  wire logic       write_allowed,
  input  wire logic       req,
  input  wire logic       early,
  input  wire sfpg_cmd_t  req_code,
  input  wire logic [7:0] req_data,
  output logic            cmd_valid,
  output sfpg_cmd_t       cmd_code,
  output logic [7:0]      cmd_data
);
  logic wr_class;
  assign wr_class = req_code >= CMD_WRITE_UNLOCK;
  initial begin
    cmd_valid = 1'b0;
    cmd_code  = CMD_NONE;
    cmd_data  = 8'h00;
  end
  // Early lets the bench break the host timing on purpose
  always @(posedge clk) begin
    cmd_valid <= req && (early || (select_allowed && (!wr_class || write_allowed)));
    cmd_code  <= req ? req_code : CMD_NONE;
    cmd_data  <= req ? req_data : ~cmd_data;
  end
endmodule : sfpg_host_model

// File: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top import sfpg_pkg::*; ;
  localparam int SW = 10, WA = 50, BC = 20;
  logic clk, reset_n, inh, vmin, req, early, cmd_valid, core_reset_n, select_allowed, write_allowed;
  logic cmd_accept, cmd_reject, rd_valid, write_unlock_latch, cycle_active_flag, cycle_cut;
  logic [7:0] req_data, cmd_data, rd_data, r, d, user;
  sfpg_cmd_t req_code, cmd_code;
  int failures = 0, samples_checked = 0, cyc = 0, t0;
  logic [31:0] seed;
  sfpg_powerup_gate #(.SELECT_WAIT_CYC(SW), .WRITE_ACCEPT_CYC(WA), .BUSY_CYC(BC)) DUT (.clk(clk),
    .reset_n(reset_n), .supply_above_inhibit(inh), .supply_above_min(vmin), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_data(cmd_data), .core_reset_n(core_reset_n), .select_allowed(select_allowed),
    .write_allowed(write_allowed), .cmd_accept(cmd_accept), .cmd_reject(cmd_reject), .rd_valid(rd_valid),
    .rd_data(rd_data), .write_unlock_latch(write_unlock_latch), .cycle_active_flag(cycle_active_flag),
    .cycle_cut(cycle_cut));
  sfpg_host_model host (.clk(clk), .select_allowed(select_allowed), .write_allowed(write_allowed),
    .req(req), .early(early), .req_code(req_code), .req_data(req_data), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_data(cmd_data));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  function automatic logic [7:0] st(input logic [7:0] u, input logic wl, input logic act);
    return {u[7:2], wl, act};
  endfunction : st
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk8
  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask : chk1
  // Answer code: 0 none, 1 accept, 2 reject
  task automatic send(input sfpg_cmd_t c, input logic [7:0] dd, input logic [1:0] e);
    logic [1:0] g;
    g = 2'b00;
    // Stale read data must not satisfy a later check
    r = 8'hxx;
    @(posedge clk);
    req_code <= c;
    req_data <= dd;
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    repeat (4) begin
      @(posedge clk);
      #1;
      if (g == 2'b00) g = {cmd_reject, cmd_accept};
      if (rd_valid) r = rd_data;
    end
    chk8({6'h00, g}, {6'h00, e});
  endtask : send
  task automatic supply(input logic i, input logic m);
    @(posedge clk);
    inh <= i;
    vmin <= m;
  endtask : supply
  task automatic end_sim;
    $display("compares %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  initial begin
    #(3000 * 50);
    failures++;
    end_sim;
  end
  initial begin
    reset_n = 0; inh = 0; vmin = 0; req = 0; early = 1; req_code = CMD_NONE; req_data = 8'h00;
    seed = 32'd27;
    user = 8'h00;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    send(CMD_READ, 8'h00, 2'd0);
    chk1(core_reset_n, 1'b0);
    $display("test low_supply done");
    supply(1'b1, 1'b1);
    t0 = cyc;
    send(CMD_READ, 8'h00, 2'd2);
    while (!select_allowed && cyc - t0 < 100) @(posedge clk);
    chk1((cyc - t0) inside {SW + 1, SW + 2}, 1'b1);
    chk1(write_unlock_latch | cycle_active_flag, 1'b0);
    send(CMD_READ, 8'h00, 2'd1);
    chk8(r, 8'hff);
    send(CMD_STATUS_READ, 8'h00, 2'd1);
    chk8(r, st(8'h00, 1'b0, 1'b0));
    send(CMD_WRITE_UNLOCK, 8'h00, 2'd2);
    while (!write_allowed && cyc - t0 < 200) @(posedge clk);
    chk1((cyc - t0) inside {WA + 1, WA + 2}, 1'b1);
    $display("test power_up done");
    early <= 1'b0;
    for (int k = 4; k < 8; k++) begin
      seed = xs(seed);
      d = seed[7:0];
      send(sfpg_cmd_t'(k), d, 2'd2);
      send(CMD_WRITE_UNLOCK, 8'h00, 2'd1);
      chk1(write_unlock_latch, 1'b1);
      send(sfpg_cmd_t'(k), d, 2'd1);
      if (k == 7) user = d;
      send(CMD_READ, 8'h00, 2'd2);
      send(CMD_STATUS_READ, 8'h00, 2'd1);
      chk8({6'h00, r[1:0]}, 8'h03);
      repeat (BC + 4) @(posedge clk);
      send(CMD_STATUS_READ, 8'h00, 2'd1);
      chk8(r, st(user, 1'b0, 1'b0));
    end
    $display("test write_cmds done");
    send(CMD_WRITE_UNLOCK, 8'h00, 2'd1);
    send(CMD_PAGE_WRITE, 8'h5a, 2'd1);
    supply(1'b0, 1'b1);
    early <= 1'b1;
    d = 8'h00;
    repeat (3) begin
      @(posedge clk);
      #1;
      d[0] = d[0] | cycle_cut;
    end
    chk1(d[0], 1'b1);
    chk1(core_reset_n | write_unlock_latch | cycle_active_flag, 1'b0);
    send(CMD_STATUS_READ, 8'h00, 2'd0);
    $display("test power_down done");
    supply(1'b1, 1'b0);
    repeat (WA - 2) @(posedge clk);
    supply(1'b1, 1'b1);
    t0 = cyc;
    send(CMD_READ, 8'h00, 2'd2);
    while (!select_allowed && cyc - t0 < 100) @(posedge clk);
    chk1((cyc - t0) inside {SW + 1, SW + 2}, 1'b1);
    chk1(write_allowed, 1'b1);
    send(CMD_STATUS_READ, 8'h00, 2'd1);
    chk8(r, st(user, 1'b0, 1'b0));
    $display("test late_min done");
    end_sim;
  end
endmodule : tb_top

// File: logic/sfpg_delay_timer.sv
`timescale 1ns/1ps
module sfpg_delay_timer #(
  parameter int COUNT = 600,
  parameter int W     = $clog2(COUNT + 1)
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic arm,
  output logic      done
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         done;
  } sfpg_tmr_t;

  localparam logic [W-1:0] LAST = W'(COUNT - 1);

  sfpg_tmr_t s_q;
  sfpg_tmr_t s_d;

  always_comb begin
    s_d = s_q;
    if (!arm) begin
      s_d = '0;
    end else if (!s_q.done) begin
      s_d.cnt = s_q.cnt + W'(1);
      s_d.done = (s_q.cnt == LAST);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done = s_q.done;
endmodule : sfpg_delay_timer

// File: logic/sfpg_params.svh
`ifndef SFPG_PARAMS_SVH
`define SFPG_PARAMS_SVH
`define SFPG_CLK_MHZ            20
`define SFPG_SELECT_WAIT_NS     30000
`define SFPG_SELECT_WAIT_CYC    ((`SFPG_SELECT_WAIT_NS * `SFPG_CLK_MHZ + 999) / 1000)
`define SFPG_WRITE_ACCEPT_US    1000
`define SFPG_WRITE_ACCEPT_MAX_US 10000
`define SFPG_WRITE_ACCEPT_CYC   (`SFPG_WRITE_ACCEPT_US * `SFPG_CLK_MHZ)
`define SFPG_BUSY_CYC           64
`define SFPG_ERASED_BYTE        8'hff
`define SFPG_STATUS_RESET       8'h00
`define SFPG_ST_ACTIVE_BIT      0
`define SFPG_ST_UNLOCK_BIT      1
`define SFPG_ST_USER_LSB        2
`endif

// File: logic/sfpg_pkg.sv
package sfpg_pkg;
  typedef enum logic [2:0] {
    CMD_NONE         = 3'b000,
    CMD_READ         = 3'b001,
    CMD_STATUS_READ  = 3'b010,
    CMD_WRITE_UNLOCK = 3'b011,
    CMD_PAGE_WRITE   = 3'b100,
    CMD_BLOCK_CLEAR  = 3'b101,
    CMD_ARRAY_CLEAR  = 3'b110,
    CMD_STATUS_WRITE = 3'b111
  } sfpg_cmd_t;

  typedef enum logic [1:0] {
    PH_OFF  = 2'b00,
    PH_HOLD = 2'b01,
    PH_READ = 2'b10,
    PH_FULL = 2'b11
  } sfpg_phase_t;
endpackage : sfpg_pkg

// File: logic/sfpg_powerup_gate.sv
// What this block does
// - Below write-inhibit level, logic held reset and no instruction answered.
// - Write-class instructions rejected until write-accept delay (1 to 10 ms) elapses.
// - After select wait, reads are executed even while write-accept delay runs.
// - Leaving power-on reset: standby, unlock latch and cycle-active flag cleared.
// - Supply falling below inhibit level disables everything; cut cycle may corrupt.
// - Delivered array bytes read FFh, status register reads 00h.
// - Write-unlock sets latch; program, erase, status write need latch set.
// - Cycle-active flag is 1 during self-timed cycle, 0 after completion.
`timescale 1ns/1ps
`include "sfpg_params.svh"
module sfpg_powerup_gate import sfpg_pkg::*; #(
  parameter int SELECT_WAIT_CYC  = `SFPG_SELECT_WAIT_CYC,
  parameter int WRITE_ACCEPT_CYC = `SFPG_WRITE_ACCEPT_CYC,
  parameter int BUSY_CYC         = `SFPG_BUSY_CYC
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       supply_above_inhibit,
  input  wire logic       supply_above_min,
  input  wire logic       cmd_valid,
  input  wire sfpg_cmd_t  cmd_code,
  input  wire logic [7:0] cmd_data,
  output logic            core_reset_n,
  output logic            select_allowed,
  output logic            write_allowed,
  output logic            cmd_accept,
  output logic            cmd_reject,
  output logic            rd_valid,
  output logic [7:0]      rd_data,
  output logic            write_unlock_latch,
  output logic            cycle_active_flag,
  output logic            cycle_cut
);
  typedef struct packed {
    sfpg_phase_t phase;
    logic        unlock;
    logic        busy;
    logic [5:0]  user;
    logic        acc;
    logic        rej;
    logic        rdv;
    logic [7:0]  rdd;
    logic        cut;
  } sfpg_state_t;

  sfpg_state_t s_q;
  sfpg_state_t s_d;
  logic        sel_done;
  logic        wa_done;
  logic        busy_done;
  logic        is_write;
  logic        is_cycle;
  logic [7:0]  status;

  // Select wait only starts once both thresholds are met
  sfpg_delay_timer #(.COUNT(SELECT_WAIT_CYC)) u_select_wait (
    .clk     (clk),
    .reset_n (reset_n),
    .arm     (supply_above_inhibit && supply_above_min),
    .done    (sel_done)
  );

  sfpg_delay_timer #(.COUNT(WRITE_ACCEPT_CYC)) u_write_accept (
    .clk     (clk),
    .reset_n (reset_n),
    .arm     (supply_above_inhibit),
    .done    (wa_done)
  );

  sfpg_delay_timer #(.COUNT(BUSY_CYC)) u_busy_cycle (
    .clk     (clk),
    .reset_n (reset_n),
    .arm     (s_q.busy),
    .done    (busy_done)
  );

  // Write class: everything the write-accept delay must hold back
  assign is_cycle = (cmd_code == CMD_PAGE_WRITE) || (cmd_code == CMD_BLOCK_CLEAR) ||
                    (cmd_code == CMD_ARRAY_CLEAR) || (cmd_code == CMD_STATUS_WRITE);
  assign is_write = is_cycle || (cmd_code == CMD_WRITE_UNLOCK);

  // Status layout: stored user bits, unlock latch, cycle flag in bit 0
  always_comb begin
    status = {s_q.user, s_q.unlock, s_q.busy};
  end

  always_comb begin
    s_d = s_q;
    s_d.acc = 1'b0;
    s_d.rej = 1'b0;
    s_d.rdv = 1'b0;
    s_d.cut = 1'b0;
    if (!supply_above_inhibit) begin
      // Nonvolatile user status bits survive the supply drop
      s_d.phase = PH_OFF;
      s_d.unlock = 1'b0;
      s_d.busy = 1'b0;
      s_d.cut = s_q.busy;
    end else begin
      // Phase is registered, so a command sees the phase of the previous edge
      unique case ({sel_done, wa_done})
        2'b10:   s_d.phase = PH_READ;
        2'b11:   s_d.phase = PH_FULL;
        default: s_d.phase = PH_HOLD;
      endcase
      // Latch drops with the flag, so every cycle needs a fresh unlock
      if (busy_done) begin
        s_d.busy = 1'b0;
        s_d.unlock = 1'b0;
      end
      if (cmd_valid && cmd_code != CMD_NONE && s_q.phase != PH_OFF) begin
        if (s_q.phase == PH_HOLD) begin
          s_d.rej = 1'b1;
        end else if (cmd_code == CMD_STATUS_READ) begin
          s_d.acc = 1'b1;
          s_d.rdv = 1'b1;
          s_d.rdd = status;
        end else if (s_q.busy) begin
          s_d.rej = 1'b1;
        end else if (cmd_code == CMD_READ) begin
          // No array storage: every byte reads as erased
          s_d.acc = 1'b1;
          s_d.rdv = 1'b1;
          s_d.rdd = `SFPG_ERASED_BYTE;
        end else if (is_write && s_q.phase != PH_FULL) begin
          s_d.rej = 1'b1;
        end else if (cmd_code == CMD_WRITE_UNLOCK) begin
          s_d.acc = 1'b1;
          s_d.unlock = 1'b1;
        end else if (is_cycle && !s_q.unlock) begin
          s_d.rej = 1'b1;
        end else begin
          s_d.acc = 1'b1;
          s_d.busy = 1'b1;
          if (cmd_code == CMD_STATUS_WRITE) begin
            s_d.user = cmd_data[7:`SFPG_ST_USER_LSB];
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q <= '0;
      // Last read byte shows the cleared status after reset
      s_q.rdd <= `SFPG_STATUS_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign core_reset_n       = (s_q.phase != PH_OFF);
  assign select_allowed     = s_q.phase[1];
  assign write_allowed      = (s_q.phase == PH_FULL);
  assign cmd_accept         = s_q.acc;
  assign cmd_reject         = s_q.rej;
  assign rd_valid           = s_q.rdv;
  assign rd_data            = s_q.rdd;
  assign write_unlock_latch = s_q.unlock;
  assign cycle_active_flag  = s_q.busy;
  assign cycle_cut          = s_q.cut;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_off_silent: assert property (!supply_above_inhibit |=>
    !core_reset_n && !cmd_accept && !cmd_reject && !write_unlock_latch && !cycle_active_flag)
    else $error("answer while below inhibit level");
  a_write_gated: assert property (supply_above_inhibit && cmd_valid && is_write && select_allowed &&
    !write_allowed && !cycle_active_flag |=> cmd_reject && !cmd_accept)
    else $error("write accepted before write-accept delay");
  a_read_early: assert property (supply_above_inhibit && cmd_valid && cmd_code == CMD_READ &&
    select_allowed && !cycle_active_flag |=> cmd_accept && rd_valid && rd_data == 8'hff)
    else $error("read refused after select wait");
  a_unlock_set: assert property (supply_above_inhibit && cmd_valid && cmd_code == CMD_WRITE_UNLOCK &&
    write_allowed && !cycle_active_flag |=> write_unlock_latch)
    else $error("unlock latch not set");
  a_lock_needed: assert property (cmd_valid && is_cycle && !write_unlock_latch |=> !cmd_accept)
    else $error("cycle started without unlock");
  a_busy_hold: assert property ($rose(cycle_active_flag) && supply_above_inhibit |->
    (cycle_active_flag && supply_above_inhibit)[*2] or ##[0:1] !supply_above_inhibit)
    else $error("cycle flag dropped early");
  a_busy_end: assert property ($fell(cycle_active_flag) |-> !write_unlock_latch)
    else $error("unlock latch left set after cycle");
  a_cut_flag: assert property (cycle_active_flag && !supply_above_inhibit |=> cycle_cut && !cycle_active_flag)
    else $error("cut cycle not flagged");
  a_hold_refuse: assert property (supply_above_inhibit && cmd_valid && cmd_code != CMD_NONE &&
    core_reset_n && !select_allowed |=> cmd_reject)
    else $error("command answered before select wait");
  a_status_read: assert property (cmd_valid && cmd_code == CMD_STATUS_READ && select_allowed &&
    supply_above_inhibit |=> rd_valid && rd_data[0] == $past(cycle_active_flag))
    else $error("status read wrong flag");

  // Antecedents sample the same registered phase that the decision used
  a_por_clear: assert property ($rose(core_reset_n) |-> !write_unlock_latch && !cycle_active_flag)
    else $error("latch or flag set when leaving reset");
  a_no_early_read: assert property (!select_allowed |=> !rd_valid && !cmd_accept)
    else $error("command executed before select wait");
  a_no_early_write: assert property (cmd_valid && is_write && !write_allowed |=> !cmd_accept)
    else $error("write-class command executed early");
  a_cut_pulse: assert property (cycle_cut |=> !cycle_cut && !cycle_active_flag)
    else $error("cut flag longer than one cycle");
  a_busy_refuse: assert property (cycle_active_flag && supply_above_inhibit && cmd_valid &&
    cmd_code == CMD_READ |=> cmd_reject && !rd_valid)
    else $error("read executed during self-timed cycle");
  a_cycle_start: assert property (supply_above_inhibit && cmd_valid && is_cycle && write_unlock_latch &&
    write_allowed && !cycle_active_flag |=> cmd_accept && cycle_active_flag)
    else $error("unlocked cycle command not started");
  a_erased_read: assert property (rd_valid && $past(cmd_code) == CMD_READ |-> rd_data == `SFPG_ERASED_BYTE)
    else $error("array byte not erased value");

  c_read_early: cover property (select_allowed && !write_allowed && cmd_accept && rd_valid);
  c_full_cycle: cover property ($fell(cycle_active_flag) && supply_above_inhibit);
  c_cut_cycle:  cover property (cycle_cut);
  c_hold_reject: cover property (core_reset_n && !select_allowed && cmd_reject);
  c_unlock_set: cover property ($rose(write_unlock_latch));
endmodule : sfpg_powerup_gate
